/* verif/ess_sequencer_sva.sv */
// Purpose: Port checker for the external subroutine sequencer
// Assumes: One clock, asynchronous active-low reset
// Notes: Helper flops note each accepted execute and config command, and stores only with memory fitted
`timescale 1ns/1ns
module ess_sequencer_sva
  import ess_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic mode_select_input,
  input wire logic memory_fitted,
  input wire ess_host_cmd_type host_cmd,
  input wire logic host_ready,
  input wire logic routine_done,
  input wire logic routine_error,
  input wire logic executing,
  input wire logic output_register_disable,
  input wire logic pipeline_register_disable,
  input wire logic [ESS_ADDR_W-1:0] memory_side_address_bus,
  input wire logic [ESS_DATA_W-1:0] memory_side_data_bus_out,
  input wire logic memory_side_data_bus_oe,
  input wire logic code_select_n,
  input wire logic data_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n
);
  logic acc_exec, acc_cfg, acc_st, st_code, fit;
  logic [1:0] cfg_bits;
  logic [ESS_ADDR_W-1:0] exp_addr;
  logic [ESS_DATA_W-1:0] st_data;
  wire logic take = host_ready && host_cmd.valid && !mode_select_input;
  wire logic is_st = host_cmd.kind inside {ESS_CMD_STORE_CODE, ESS_CMD_STORE_DATA};
  // No reset: the clock runs during reset and host_ready is low then
  always_ff @(posedge clk)
  begin
    acc_exec <= take && host_cmd.kind == ESS_CMD_EXTERNAL_EXECUTE;
    acc_cfg <= take && host_cmd.kind == ESS_CMD_WRITE_CONFIG;
    acc_st <= take && is_st && memory_fitted;
    st_code <= host_cmd.kind == ESS_CMD_STORE_CODE;
    fit <= memory_fitted;
    cfg_bits <= host_cmd.data[5:4];
    exp_addr <= is_st ? host_cmd.addr : {10'h000, host_cmd.data[4:0], 1'h0};
    st_data <= host_cmd.data;
  end
  // --------------------------------
  // Properties
  // --------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_wr;
    !write_strobe_n && memory_side_data_bus_oe ##1 write_strobe_n && !memory_side_data_bus_oe;
  endsequence
  property p_store;
    acc_st |-> memory_side_address_bus == exp_addr && memory_side_data_bus_out == st_data
      && code_select_n == !st_code ##0 s_wr;
  endproperty
  property p_sel;
    !read_strobe_n || !write_strobe_n |-> code_select_n != data_select_n;
  endproperty
  property p_oe;
    memory_side_data_bus_oe == !write_strobe_n;
  endproperty
  property p_start;
    acc_exec && fit |-> executing && !code_select_n && !read_strobe_n
      && memory_side_address_bus == exp_addr;
  endproperty
  property p_only;
    $rose(executing) |-> acc_exec;
  endproperty
  property p_err;
    acc_exec && !fit |-> routine_error && !executing;
  endproperty
  property p_done;
    routine_done |-> !executing && host_ready && $past(executing);
  endproperty
  property p_cfg;
    acc_cfg |-> {output_register_disable, pipeline_register_disable} == cfg_bits;
  endproperty
  a_store: assert property (p_store) else $error("store cycle wrong");
  a_sel: assert property (p_sel) else $error("space select wrong");
  a_oe: assert property (p_oe) else $error("drive enable wrong");
  a_start: assert property (p_start) else $error("entry fetch wrong");
  a_only: assert property (p_only) else $error("run without command");
  a_err: assert property (p_err) else $error("no memory not flagged");
  a_done: assert property (p_done) else $error("return not idle");
  a_cfg: assert property (p_cfg) else $error("config bits wrong");
endmodule
bind ess_sequencer ess_sequencer_sva ess_sequencer_sva_inst (.clk, .rstn, .mode_select_input,
  .memory_fitted, .host_cmd, .host_ready, .routine_done, .routine_error, .executing,
  .output_register_disable, .pipeline_register_disable, .memory_side_address_bus,
  .memory_side_data_bus_out, .memory_side_data_bus_oe, .code_select_n, .data_select_n,
  .read_strobe_n, .write_strobe_n);

/* verif/ess_sram_model.sv */
// Purpose: Static memory on the memory side, code and data spaces
// Assumes: Strobes and address are registered by the sequencer
// Notes: Read lines flip each cycle that neither writes nor reads a stored word, so stale data never passes
`timescale 1ns/1ns
module ess_sram_model
  import ess_pkg::*;
(
  input wire logic clk,
  input wire logic [ESS_ADDR_W-1:0] memory_side_address_bus,
  input wire logic [ESS_DATA_W-1:0] memory_side_data_bus_out,
  input wire logic memory_side_data_bus_oe,
  input wire logic code_select_n,
  input wire logic data_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  output logic [ESS_DATA_W-1:0] memory_side_data_bus_in
);
  logic [ESS_DATA_W-1:0] mem [int];
  wire logic [16:0] key = {code_select_n, memory_side_address_bus};
  initial memory_side_data_bus_in = 32'h0;
  // Mid-cycle update keeps clear of the strobe edges
  always @(negedge clk)
  begin
    // Exactly one space select must be low for the memory to respond
    if (!write_strobe_n && memory_side_data_bus_oe && (code_select_n != data_select_n))
      mem[key] = memory_side_data_bus_out;
    else if (!read_strobe_n && (code_select_n != data_select_n) && mem.exists(key))
      memory_side_data_bus_in = mem[key];
    else
      memory_side_data_bus_in = ~memory_side_data_bus_in;
  end
endmodule

/* verif/external_subroutine_sequencer_test.sv */
// Purpose: Self-checking bench for the sequencer with a memory model
// Assumes: Inputs change 1 ns after the rising clock edge
// Notes: Expected config bits come from the words the host writes or the routine loads
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
  $display("mismatch %0t %h %h", $time, (a), (b)); end end
module external_subroutine_sequencer_test;
  import ess_pkg::*;
  logic clk = 1'h0, rstn = 1'h0, mode_select_input = 1'h0, memory_fitted = 1'h1;
  logic condition_code_input = 1'h0;
  ess_host_cmd_type host_cmd = '0;
  logic host_ready, routine_done, routine_error, executing;
  logic output_register_disable, pipeline_register_disable, memory_side_data_bus_oe;
  logic [ESS_ADDR_W-1:0] memory_side_address_bus;
  logic [ESS_DATA_W-1:0] memory_side_data_bus_out, memory_side_data_bus_in;
  logic code_select_n, data_select_n, read_strobe_n, write_strobe_n;
  wire logic [1:0] cfg = {output_register_disable, pipeline_register_disable};
  int errors = 0, check_count = 0, cycles = 0, seed = 32'h95EA24FC, n, exp_cfg = 32'hFFC28;
  logic [31:0] cw [2] = '{32'hFFC08, 32'hFFC28};
  int data_ref [int];
  logic [31:0] prog [16] = '{{ESS_OP_JUMP_CC, 28'h0000104}, {ESS_OP_LOAD_CONFIG, 28'h0000010},
    {ESS_OP_CLEAR_STACK, 28'h0}, {ESS_OP_RETURN, 28'h0}, {ESS_OP_LOAD_CONFIG, 28'h000FFFF},
    {ESS_OP_CLEAR_STACK, 28'h0}, {ESS_OP_RETURN, 28'h0}, {ESS_OP_JUMP_NCC, 28'h0000109},
    {ESS_OP_RETURN, 28'h0}, {ESS_OP_NOP, 28'h0}, {ESS_OP_CALL, 28'h000010C},
    {ESS_OP_RETURN, 28'h0}, {ESS_OP_CALL, 28'h000010E}, {ESS_OP_RETURN, 28'h0},
    {ESS_OP_LOAD_CONFIG, 28'h000FFFF}, {ESS_OP_RETURN, 28'h0}};
  ess_sequencer ess_sequencer_inst (.clk, .rstn, .mode_select_input, .memory_fitted,
    .condition_code_input, .host_cmd, .host_ready, .routine_done, .routine_error, .executing,
    .output_register_disable, .pipeline_register_disable, .memory_side_address_bus,
    .memory_side_data_bus_out, .memory_side_data_bus_oe, .memory_side_data_bus_in,
    .code_select_n, .data_select_n, .read_strobe_n, .write_strobe_n);
  ess_sram_model ess_sram_model_inst (.clk, .memory_side_address_bus, .memory_side_data_bus_out,
    .memory_side_data_bus_oe, .code_select_n, .data_select_n, .read_strobe_n, .write_strobe_n,
    .memory_side_data_bus_in);
  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic finish_test;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  // One edge always passes first, so valid never drops and rises in one step
  task automatic send(ess_cmd_type k, logic [15:0] a, logic [31:0] d);
    int i;
    i = 0;
    // Bench copy of the data space, source of the expected config word of each run
    if (k == ESS_CMD_STORE_DATA)
      data_ref[a] = d;
    do
    begin
      step();
      i++;
    end
    while (host_ready !== 1'b1 && i < 99);
    host_cmd = '{1'b1, k, a, d};
    step();
    host_cmd.valid = 1'b0;
  endtask
  task automatic run(int e, logic c, int x);
    int i;
    condition_code_input = c;
    exp_cfg = data_ref[x];
    send(ESS_CMD_EXTERNAL_EXECUTE, 16'h0000, 32'({$random(seed)} << 5 | e));
    `CHK(executing, 1'b1)
    for (i = 0; i < 99 && routine_done !== 1'b1; i++)
      step();
    `CHK(routine_done, 1'b1)
    `CHK(cfg, 2'(exp_cfg >> 4))
  endtask
  initial
  begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      finish_test();
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    rstn = 1'b1;
    `CHK(cfg, 2'(exp_cfg >> 4))
    foreach (cw[i])
    begin
      exp_cfg = cw[i];
      send(ESS_CMD_WRITE_CONFIG, 16'h0000, cw[i]);
      `CHK(cfg, 2'(exp_cfg >> 4))
    end
    // Entries 29 to 31 are kept for fixed routines
    n = {$random(seed)} % 29;
    send(ESS_CMD_STORE_DATA, 16'h0010, 32'hFFC08);
    send(ESS_CMD_STORE_DATA, 16'hFFFF, 32'hFFC18);
    send(ESS_CMD_STORE_CODE, 16'hFFFF, 32'h00000020);
    send(ESS_CMD_STORE_CODE, 16'(2 * n), {ESS_OP_JUMP, 28'h0000100});
    send(ESS_CMD_STORE_CODE, 16'h003E, {ESS_OP_JUMP, 28'h0000100});
    send(ESS_CMD_STORE_CODE, 16'h003C, {ESS_OP_JUMP, 28'h0000107});
    send(ESS_CMD_STORE_CODE, 16'h003A, 32'hF000_0000);
    // Each path leaves both stack flags clear before its final return
    foreach (prog[i])
      send(ESS_CMD_STORE_CODE, 16'h0100 + 16'(i), prog[i]);
    // Expected words alternate so every run moves the config bits
    run(n, 1'b1, 16'hFFFF);
    run(n, 1'b0, 16'h0010);
    run(30, 1'b0, 16'hFFFF);
    run(31, 1'b0, 16'h0010);
    // Undefined opcode in entry 29 ends the routine with an error pulse
    send(ESS_CMD_EXTERNAL_EXECUTE, 16'h0000, 32'h1D);
    repeat (2) step();
    `CHK({routine_error, executing, host_ready}, 3'b101)
    memory_fitted = 1'b0;
    send(ESS_CMD_EXTERNAL_EXECUTE, 16'h0000, 32'(n));
    `CHK({routine_error, executing}, 2'b10)
    memory_fitted = 1'b1;
    mode_select_input = 1'b1;
    step();
    host_cmd = '{1'b1, ESS_CMD_WRITE_CONFIG, 16'h0000, 32'hFFC28};
    repeat (3) step();
    `CHK({host_ready, cfg}, {1'b0, 2'(exp_cfg >> 4)})
    host_cmd.valid = 1'b0;
    finish_test();
  end
endmodule

/* verilog/ess_pkg.sv */
// Purpose: Shared types and constants for the external subroutine sequencer
// Assumes: One 100 MHz clock, memory-side SRAM answers within one cycle
// Notes: Instruction word layout and opcodes are local to this block
package ess_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int ESS_ADDR_W = 16;
  localparam int ESS_DATA_W = 32;
  localparam int ESS_CFG_W = 20;
  localparam int ESS_ENTRY_W = 5;
  localparam int ESS_OP_POS = 28;
  localparam int ESS_OP_W = 4;

  // ----------------------------------------
  // Configuration word
  // ----------------------------------------
  localparam logic [ESS_CFG_W-1:0] ESS_CFG_RESET = 20'hFFC28;
  localparam logic [ESS_CFG_W-1:0] ESS_CFG_ALL_PIPES = 20'hFFC08;
  localparam logic [ESS_CFG_W-1:0] ESS_CFG_PIPE_ONLY = 20'hFFC28;
  localparam int ESS_CFG_OUTREG_DIS_BIT = 5;
  localparam int ESS_CFG_PIPE_DIS_BIT = 4;

  // ----------------------------------------
  // Subroutine stack
  // ----------------------------------------
  localparam int ESS_STK_FLAG_BIT = 31;
  localparam logic [ESS_DATA_W-1:0] ESS_STK_RESET = 32'h0000_0000;
  localparam logic [ESS_ADDR_W-1:0] ESS_JUMP_TABLE_BASE = 16'h0000;
  localparam logic [ESS_ADDR_W-1:0] ESS_PC_STEP = 16'h0001;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ESS_CMD_NONE,
    ESS_CMD_STORE_CODE,
    ESS_CMD_STORE_DATA,
    ESS_CMD_EXTERNAL_EXECUTE,
    ESS_CMD_WRITE_CONFIG
  } ess_cmd_type;

  typedef enum logic [ESS_OP_W-1:0] {
    ESS_OP_NOP = 4'h0,
    ESS_OP_JUMP = 4'h1,
    ESS_OP_JUMP_CC = 4'h2,
    ESS_OP_JUMP_NCC = 4'h3,
    ESS_OP_CALL = 4'h4,
    ESS_OP_RETURN = 4'h5,
    ESS_OP_LOAD_CONFIG = 4'h6,
    ESS_OP_CLEAR_STACK = 4'h7
  } ess_op_type;

  typedef enum {
    ESS_ST_IDLE,
    ESS_ST_WRITE,
    ESS_ST_FETCH,
    ESS_ST_EXEC,
    ESS_ST_DATA_READ
  } ess_state_type;

  typedef struct packed {
    logic valid;
    ess_cmd_type kind;
    logic [ESS_ADDR_W-1:0] addr;
    logic [ESS_DATA_W-1:0] data;
  } ess_host_cmd_type;

  typedef struct packed {
    logic [ESS_ADDR_W-1:0] addr;
    logic [ESS_DATA_W-1:0] wdata;
    logic data_oe;
    logic code_select_n;
    logic data_select_n;
    logic read_strobe_n;
    logic write_strobe_n;
  } ess_mem_type;

  localparam ess_mem_type ESS_MEM_IDLE = '{
    addr: 16'h0000, wdata: 32'h0000_0000, data_oe: 1'b0,
    code_select_n: 1'b1, data_select_n: 1'b1,
    read_strobe_n: 1'b1, write_strobe_n: 1'b1};

endpackage

/* verilog/ess_sequencer.sv */
// Purpose: Memory-port sequencer that loads SRAM and runs external routines
// Assumes: Host commands arrive synchronous to clk; SRAM read data valid
//          one cycle after address and strobes are driven
// Notes: Floating-point datapath is outside this block
//
// Notes on behaviour
// - Works with or without external memory fitted
// - Control combinations separate code and data accesses
// - Host bus words written out to memory side
// - Two separate 64K-word spaces, code and data
// - Pins drive static memory with no glue
// - Condition input branches external code only
// - External code starts only on execute command
// - Jump table of 32 entries, entry n at 2n
// - Return with empty stack goes idle
// - Config word sets output and pipeline registers
`timescale 1ns/1ns
module ess_sequencer
  import ess_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic mode_select_input,
  input wire logic memory_fitted,
  input wire logic condition_code_input,
  input wire ess_host_cmd_type host_cmd,
  output logic host_ready,
  output logic routine_done,
  output logic routine_error,
  output logic executing,
  output logic output_register_disable,
  output logic pipeline_register_disable,
  output logic [ESS_ADDR_W-1:0] memory_side_address_bus,
  output logic [ESS_DATA_W-1:0] memory_side_data_bus_out,
  output logic memory_side_data_bus_oe,
  input wire logic [ESS_DATA_W-1:0] memory_side_data_bus_in,
  output logic code_select_n,
  output logic data_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    ess_state_type st;
    logic [ESS_ADDR_W-1:0] pc;
    logic [ESS_DATA_W-1:0] instr;
    logic [ESS_DATA_W-1:0] stk0;
    logic [ESS_DATA_W-1:0] stk1;
    logic [ESS_CFG_W-1:0] cfg;
    ess_mem_type mem;
    logic ready;
    logic done;
    logic err;
    logic busy;
  } ess_seq_type;

  localparam ess_seq_type ESS_SEQ_RESET = '{
    st: ESS_ST_IDLE, pc: 16'h0000, instr: 32'h0000_0000,
    stk0: ESS_STK_RESET, stk1: ESS_STK_RESET, cfg: ESS_CFG_RESET,
    mem: ESS_MEM_IDLE, ready: 1'b0, done: 1'b0, err: 1'b0, busy: 1'b0};

  ess_seq_type s;
  ess_seq_type next_s;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic accept;
    ess_op_type op;
    logic [ESS_ADDR_W-1:0] target;
    logic [ESS_ADDR_W-1:0] pc_inc;
    logic take;
    accept = 1'b0;
    op = ess_op_type'(s.instr[ESS_OP_POS +: ESS_OP_W]);
    target = s.instr[ESS_ADDR_W-1:0];
    pc_inc = s.pc + ESS_PC_STEP;
    take = 1'b0;
    next_s = s;
    next_s.done = 1'b0;
    next_s.err = 1'b0;
    next_s.mem = ESS_MEM_IDLE;
    // Host-independent strap blocks all coprocessor commands
    accept = s.ready && host_cmd.valid && !mode_select_input;
    case (s.st)
      ESS_ST_IDLE:
      begin
        if (accept)
        begin
          case (host_cmd.kind)
            ESS_CMD_STORE_CODE, ESS_CMD_STORE_DATA:
            begin
              // Without memory the store is dropped, nothing else changes
              if (memory_fitted)
              begin
                // Host bus word passed straight to the memory side
                next_s.mem.addr = host_cmd.addr;
                next_s.mem.wdata = host_cmd.data;
                next_s.mem.data_oe = 1'b1;
                next_s.mem.write_strobe_n = 1'b0;
                next_s.mem.code_select_n = (host_cmd.kind != ESS_CMD_STORE_CODE);
                next_s.mem.data_select_n = (host_cmd.kind != ESS_CMD_STORE_DATA);
                next_s.st = ESS_ST_WRITE;
              end
            end
            ESS_CMD_EXTERNAL_EXECUTE:
            begin
              if (memory_fitted)
              begin
                // Dispatch through the jump table, two slots per entry
                next_s.pc = ESS_JUMP_TABLE_BASE
                  + {10'h000, host_cmd.data[ESS_ENTRY_W-1:0], 1'b0};
                next_s.mem.addr = next_s.pc;
                next_s.mem.code_select_n = 1'b0;
                next_s.mem.read_strobe_n = 1'b0;
                next_s.busy = 1'b1;
                next_s.st = ESS_ST_FETCH;
              end
              else
              begin
                // No code space: refuse and report, stay usable
                next_s.err = 1'b1;
              end
            end
            ESS_CMD_WRITE_CONFIG:
            begin
              next_s.cfg = host_cmd.data[ESS_CFG_W-1:0];
            end
            default:
            begin
              next_s.cfg = s.cfg;
            end
          endcase
        end
      end
      ESS_ST_WRITE:
      begin
        next_s.st = ESS_ST_IDLE;
      end
      ESS_ST_FETCH:
      begin
        // Asynchronous SRAM read data is settled by now
        next_s.instr = memory_side_data_bus_in;
        next_s.st = ESS_ST_EXEC;
      end
      ESS_ST_EXEC:
      begin
        next_s.pc = pc_inc;
        next_s.st = ESS_ST_FETCH;
        case (op)
          ESS_OP_NOP:
          begin
            take = 1'b0;
          end
          ESS_OP_JUMP:
          begin
            next_s.pc = target;
          end
          ESS_OP_JUMP_CC, ESS_OP_JUMP_NCC:
          begin
            // Only external instructions ever look at the condition input
            take = (op == ESS_OP_JUMP_CC) ? condition_code_input : !condition_code_input;
            if (take)
            begin
              next_s.pc = target;
            end
          end
          ESS_OP_CALL:
          begin
            // Two-entry stack; a third nested call is an error
            if (!s.stk0[ESS_STK_FLAG_BIT])
            begin
              next_s.stk0 = {1'b1, 15'h0000, pc_inc};
              next_s.pc = target;
            end
            else if (!s.stk1[ESS_STK_FLAG_BIT])
            begin
              next_s.stk1 = {1'b1, 15'h0000, pc_inc};
              next_s.pc = target;
            end
            else
            begin
              next_s.err = 1'b1;
              next_s.busy = 1'b0;
              next_s.st = ESS_ST_IDLE;
            end
          end
          ESS_OP_RETURN:
          begin
            if (s.stk1[ESS_STK_FLAG_BIT])
            begin
              next_s.pc = s.stk1[ESS_ADDR_W-1:0];
              next_s.stk1[ESS_STK_FLAG_BIT] = 1'b0;
            end
            else if (s.stk0[ESS_STK_FLAG_BIT])
            begin
              next_s.pc = s.stk0[ESS_ADDR_W-1:0];
              next_s.stk0[ESS_STK_FLAG_BIT] = 1'b0;
            end
            else
            begin
              // Final return: stack must already be empty
              next_s.done = 1'b1;
              next_s.busy = 1'b0;
              next_s.st = ESS_ST_IDLE;
            end
          end
          ESS_OP_LOAD_CONFIG:
          begin
            // Config word lives in data space, read before fetching on
            next_s.mem.addr = target;
            next_s.mem.data_select_n = 1'b0;
            next_s.mem.read_strobe_n = 1'b0;
            next_s.st = ESS_ST_DATA_READ;
          end
          ESS_OP_CLEAR_STACK:
          begin
            // Software way to empty the stack before the final return
            next_s.stk0[ESS_STK_FLAG_BIT] = 1'b0;
            next_s.stk1[ESS_STK_FLAG_BIT] = 1'b0;
          end
          default:
          begin
            // Unknown opcode aborts the routine rather than run wild
            next_s.err = 1'b1;
            next_s.busy = 1'b0;
            next_s.st = ESS_ST_IDLE;
          end
        endcase
        if (next_s.st == ESS_ST_FETCH)
        begin
          next_s.mem.addr = next_s.pc;
          next_s.mem.code_select_n = 1'b0;
          next_s.mem.read_strobe_n = 1'b0;
        end
      end
      ESS_ST_DATA_READ:
      begin
        next_s.cfg = memory_side_data_bus_in[ESS_CFG_W-1:0];
        next_s.mem.addr = s.pc;
        next_s.mem.code_select_n = 1'b0;
        next_s.mem.read_strobe_n = 1'b0;
        next_s.st = ESS_ST_FETCH;
      end
      default:
      begin
        next_s = ESS_SEQ_RESET;
      end
    endcase
    next_s.ready = (next_s.st == ESS_ST_IDLE) && !mode_select_input;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s <= ESS_SEQ_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign host_ready = s.ready;
  assign routine_done = s.done;
  assign routine_error = s.err;
  assign executing = s.busy;
  // 0xFFC08 clears both bits, 0xFFC28 sets only the output one
  assign output_register_disable = s.cfg[ESS_CFG_OUTREG_DIS_BIT];
  assign pipeline_register_disable = s.cfg[ESS_CFG_PIPE_DIS_BIT];
  assign memory_side_address_bus = s.mem.addr;
  assign memory_side_data_bus_out = s.mem.wdata;
  assign memory_side_data_bus_oe = s.mem.data_oe;
  assign code_select_n = s.mem.code_select_n;
  assign data_select_n = s.mem.data_select_n;
  assign read_strobe_n = s.mem.read_strobe_n;
  assign write_strobe_n = s.mem.write_strobe_n;

endmodule
